// ### rtl/gen_protect.sv
`timescale 1ns/100ps
/*
 Generator protection supervisor: seven protections with delay timers,
 alarm/shutdown drivers, fault indicator, CAN message strobes, excitation
 cutoff and an APB register file. Assumes measured values arrive already
 scaled on pclk (percent of nominal, tenths of amps) and contact pins are raw.
*/
`include "prot_cfg.svh"

module gen_protect
   import prot_pkg::*;
#(
   parameter int TICK_CYCLES = `TICK_CYCLES  // Cycles per 0.1 s
)(
   input  wire logic        pclk,          // 25 MHz clock
   input  wire logic        presetn,       // Async reset, active low
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB direction
   input  wire logic [11:0] paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic      [31:0] prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error
   input  wire logic [7:0]  volt_pct,      // Gen voltage, percent nominal
   input  wire logic [7:0]  rvar_pct,      // Reverse VAR, percent nominal
   input  wire logic [11:0] field_i,       // Field current, 0.1 A
   input  wire logic [11:0] ripple_i,      // Field ripple RMS, 0.1 A
   input  wire logic [7:0]  sense_pct,     // Sensed voltage, percent setpoint
   input  wire logic [7:0]  imbal_pct,     // Phase imbalance, percent setpoint
   input  wire logic        phase_lost,    // One phase missing
   input  wire logic        fault_reset_n, // Fault reset contact, low closed
   output logic             alarm_drv,     // Alarm output driver
   output logic             shut_drv,      // Fault shutdown output driver
   output logic             fault_led,     // Fault indicator
   output logic             can_alarm,     // CAN alarm message request pulse
   output logic             can_shut,      // CAN shutdown message request pulse
   output logic             excite_off,    // Remove excitation
   output logic             field_oc       // Field over current event
);

   // Divider counter is 24 bits wide and needs at least two states
   if (TICK_CYCLES < 2 || TICK_CYCLES > 24'hffffff) begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end

   localparam int NP = 7;                   // Protection count

   // Clamp a setting into its legal range
   function automatic logic [11:0] clamp12(input logic [11:0] v,
                                           input logic [11:0] lo,
                                           input logic [11:0] hi);
      clamp12 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp12

   function automatic logic [7:0] clamp8(input logic [7:0] v,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi);
      clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp8

   // Registers
   logic [31:0] ctrl_q;                     // Enables, types, override
   trip_set_t   ov_q, uv_q, rv_q;           // Voltage-type settings
   logic [11:0] ox_i_q, ox_t_q;             // Over excitation level, time
   logic [11:0] dio_i_q;                    // Diode ripple threshold
   logic [11:0] los_t_q;                    // Sensing loss delay
   logic [NP-1:0] trip_q;                   // Latched trips
   logic        foc_q;                      // Field overcurrent latched
   logic        fr_s1_q, fr_s2_q;           // Reset contact sync
   logic [23:0] tick_cnt_q;                 // 0.1 s divider
   logic        tick;                       // 0.1 s enable pulse
   logic [7:0]  blink_q;                    // Flash divider
   logic        blink_on_q;                 // Flash phase
   logic [NP-1:0] prev_alarm_q, prev_shut_q;// For CAN edge strobes

   wire wr = psel & penable & pwrite;
   wire rd = psel & penable & ~pwrite;

   // APB answers in the access cycle, no wait states
   assign pready = 1'b1;

   // Unmapped address flagged
   logic mapped;
   always_comb begin
      if (paddr == `OFS_CTRL)          mapped = 1'b1;
      else if (paddr == `OFS_OVTH)     mapped = 1'b1;
      else if (paddr == `OFS_UVTH)     mapped = 1'b1;
      else if (paddr == `OFS_RVTH)     mapped = 1'b1;
      else if (paddr == `OFS_OXTH)     mapped = 1'b1;
      else if (paddr == `OFS_DIOTH)    mapped = 1'b1;
      else if (paddr == `OFS_LOSDLY)   mapped = 1'b1;
      else if (paddr == `OFS_STATUS)   mapped = 1'b1;
      else if (paddr == `OFS_CLEAR)    mapped = 1'b1;
      else                             mapped = 1'b0;
   end
   assign pslverr = psel & penable & ~mapped;

   // Control register; override volatile, cleared at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr && paddr == `OFS_CTRL) begin
         ctrl_q <= {15'h0000, pwdata[16:0]};
      end
   end

   // Voltage-type settings, clamped into legal ranges on write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ov_q <= '{level: `OV_PCT_MIN, delay: `OV_DLY_MIN};
         uv_q <= '{level: `UV_PCT_MIN, delay: `UV_DLY_MIN};
         rv_q <= '{level: `RV_PCT_MIN, delay: `RV_DLY_MIN};
      end else if (wr) begin
         if (paddr == `OFS_OVTH) begin
            ov_q.level <= clamp8(pwdata[7:0], `OV_PCT_MIN, `OV_PCT_MAX);
            ov_q.delay <= clamp12(pwdata[27:16], `OV_DLY_MIN, `OV_DLY_MAX);
         end else if (paddr == `OFS_UVTH) begin
            uv_q.level <= clamp8(pwdata[7:0], `UV_PCT_MIN, `UV_PCT_MAX);
            uv_q.delay <= clamp12(pwdata[27:16], `UV_DLY_MIN, `UV_DLY_MAX);
         end else if (paddr == `OFS_RVTH) begin
            rv_q.level <= clamp8(pwdata[7:0], `RV_PCT_MIN, `RV_PCT_MAX);
            rv_q.delay <= clamp12(pwdata[27:16], `RV_DLY_MIN, `RV_DLY_MAX);
         end
      end
   end

   // Current and sensing settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ox_i_q  <= `OX_I_MAX;
         ox_t_q  <= `OX_DLY_MAX;
         dio_i_q <= `DIO_I_MAX;
         los_t_q <= `LOS_DLY_MAX;
      end else if (wr) begin
         if (paddr == `OFS_OXTH) begin
            ox_i_q <= clamp12(pwdata[11:0], 12'd0, `OX_I_MAX);
            ox_t_q <= clamp12(pwdata[27:16], `OX_DLY_MIN, `OX_DLY_MAX);
         end else if (paddr == `OFS_DIOTH) begin
            dio_i_q <= clamp12(pwdata[11:0], `DIO_I_MIN, `DIO_I_MAX);
         end else if (paddr == `OFS_LOSDLY) begin
            los_t_q <= clamp12(pwdata[11:0], 12'd0, `LOS_DLY_MAX);
         end
      end
   end

   // Contact pin synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fr_s1_q <= 1'b1;
         fr_s2_q <= 1'b1;
      end else begin
         fr_s1_q <= fault_reset_n;
         fr_s2_q <= fr_s1_q;
      end
   end

   // 0.1 s tick divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 24'h000000;
      end else if (tick) begin
         tick_cnt_q <= 24'h000000;
      end else begin
         tick_cnt_q <= tick_cnt_q + 24'h000001;
      end
   end
   assign tick = (tick_cnt_q == 24'(TICK_CYCLES - 1));

   // Per-protection enables, types, conditions and delays
   logic [NP-1:0] en, shut_type, cond;
   logic [11:0]   dly [NP];
   logic [11:0]   ox_dly;
   logic [23:0]   ox_prod;
   always_comb begin
      en        = {ctrl_q[`CTL_FR_EN], ctrl_q[`CTL_LOS_EN], ctrl_q[`CTL_DIO_EN],
                   ctrl_q[`CTL_OX_EN], ctrl_q[`CTL_RV_EN], ctrl_q[`CTL_UV_EN],
                   ctrl_q[`CTL_OV_EN]};
      shut_type = {ctrl_q[`CTL_FR_SHUT], ctrl_q[`CTL_LOS_SHUT], ctrl_q[`CTL_DIO_SHUT],
                   ctrl_q[`CTL_OX_SHUT], ctrl_q[`CTL_RV_SHUT], ctrl_q[`CTL_UV_SHUT],
                   ctrl_q[`CTL_OV_SHUT]};
      // Inverse time: delay shrinks with current over base, scaled by dial;
      // a coarse 1/x stand-in since the curve shape lives outside
      ox_prod = ox_t_q * ox_i_q;
      if (field_i == 12'd0) ox_dly = ox_t_q;
      else                  ox_dly = 12'(ox_prod / {12'd0, field_i});
      if (!ctrl_q[`CTL_OX_INV]) ox_dly = ox_t_q;
      cond[P_OV]  = volt_pct > ov_q.level;
      cond[P_UV]  = volt_pct < uv_q.level;
      cond[P_RV]  = rvar_pct > rv_q.level;
      cond[P_OX]  = field_i > ox_i_q;
      cond[P_DIO] = ripple_i > dio_i_q;
      if (ctrl_q[`CTL_THREE_PH])
         cond[P_LOS] = phase_lost | (imbal_pct >= `LOS_3PH_PCT);
      else
         cond[P_LOS] = sense_pct <= `LOS_1PH_PCT;
      cond[P_FR]  = ~fr_s2_q;
      dly[P_OV]  = ov_q.delay;
      dly[P_UV]  = uv_q.delay;
      dly[P_RV]  = rv_q.delay;
      dly[P_OX]  = ox_dly;
      dly[P_DIO] = `DIO_DLY;
      dly[P_LOS] = los_t_q;
      dly[P_FR]  = `FR_DLY;
   end

   // Delay timers, one per protection, in 0.1 s ticks
   logic [11:0] tmr_q [NP];
   logic        clr_w;
   assign clr_w = wr && (paddr == `OFS_CLEAR);
   for (genvar i = 0; i < NP; i++) begin : g_prot
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            tmr_q[i]  <= 12'd0;
            trip_q[i] <= 1'b0;
         end else begin
            if (!en[i] || !cond[i]) begin
               tmr_q[i] <= 12'd0;
            end else if (tick && tmr_q[i] < dly[i]) begin
               tmr_q[i] <= tmr_q[i] + 12'd1;
            end
            // Trip latches; a new trip beats a software clear
            if (!en[i]) begin
               trip_q[i] <= 1'b0;
            end else if (cond[i] && tmr_q[i] >= dly[i]) begin
               trip_q[i] <= 1'b1;
            end else if (clr_w && pwdata[i]) begin
               trip_q[i] <= 1'b0;
            end
         end
      end
   end

   // Field overcurrent latch, acts with no delay and no enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         foc_q <= 1'b0;
      end else if (field_i >= `FOC_LIMIT) begin
         foc_q <= 1'b1;
      end else if (clr_w && pwdata[NP]) begin
         foc_q <= 1'b0;
      end
   end

   // Verdicts; diode alarm hidden once field overcurrent shut us down
   logic [NP-1:0] rep, alarm_v, shut_v;
   always_comb begin
      rep = trip_q;
      if (foc_q) rep[P_DIO] = 1'b0;
      alarm_v = rep & ~shut_type;
      shut_v  = rep & shut_type;
   end

   // Output drivers, independent of override
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alarm_drv <= 1'b0;
         shut_drv  <= 1'b0;
      end else begin
         alarm_drv <= |alarm_v;
         shut_drv  <= |shut_v;
      end
   end

   // CAN message request pulses, one per cycle with any new trip
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_alarm_q <= '0;
         prev_shut_q  <= '0;
         can_alarm    <= 1'b0;
         can_shut     <= 1'b0;
      end else begin
         prev_alarm_q <= alarm_v;
         prev_shut_q  <= shut_v;
         can_alarm    <= |(alarm_v & ~prev_alarm_q);
         can_shut     <= |(shut_v & ~prev_shut_q);
      end
   end

   // Flash phase for the lamp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blink_q    <= 8'h00;
         blink_on_q <= 1'b0;
      end else if (tick) begin
         if (blink_q >= `BLINK_TICKS - 8'h01) begin
            blink_q    <= 8'h00;
            blink_on_q <= ~blink_on_q;
         end else begin
            blink_q <= blink_q + 8'h01;
         end
      end
   end

   // Lamp: flashing beats steady when both kinds are active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_led <= 1'b0;
      end else if (|shut_v) begin
         fault_led <= blink_on_q;
      end else begin
         fault_led <= |alarm_v;
      end
   end

   // Excitation cutoff: only OX, diode and sensing loss may cut, override
   // blocks them; field overcurrent is a hardware limit and always cuts
   logic cut_req;
   assign cut_req = trip_q[P_OX] | trip_q[P_DIO] | trip_q[P_LOS];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         excite_off <= 1'b0;
         field_oc   <= 1'b0;
      end else begin
         excite_off <= foc_q | (cut_req & ~ctrl_q[`CTL_OVERRIDE]);
         field_oc   <= foc_q;
      end
   end

   // Read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (paddr == `OFS_CTRL)          prdata = ctrl_q;
      else if (paddr == `OFS_OVTH)     prdata = {4'h0, ov_q.delay, 8'h00, ov_q.level};
      else if (paddr == `OFS_UVTH)     prdata = {4'h0, uv_q.delay, 8'h00, uv_q.level};
      else if (paddr == `OFS_RVTH)     prdata = {4'h0, rv_q.delay, 8'h00, rv_q.level};
      else if (paddr == `OFS_OXTH)     prdata = {4'h0, ox_t_q, 4'h0, ox_i_q};
      else if (paddr == `OFS_DIOTH)    prdata = {20'h00000, dio_i_q};
      else if (paddr == `OFS_LOSDLY)   prdata = {20'h00000, los_t_q};
      else if (paddr == `OFS_STATUS)
         prdata = {16'h0000, 6'h00, excite_off, foc_q, 1'b0, rep};
      if (!rd) prdata = 32'h0000_0000;
   end

endmodule : gen_protect

// ### rtl/prot_cfg.svh
/*
 Shared constants for the generator protection supervisor: APB register
 offsets, field positions, reset values, setting ranges and timing counts.
 Assumes a 25 MHz pclk; included by the design module.
*/
`ifndef PROT_CFG_SVH
`define PROT_CFG_SVH

// Clock and time base
`define CLK_HZ          25000000
`define TICK_MS         100
`define TICK_CYCLES     ((`CLK_HZ / 1000) * `TICK_MS)
`define BLINK_TICKS     8'h05

// Register byte offsets
`define OFS_CTRL        12'h000
`define OFS_OVTH        12'h004
`define OFS_UVTH        12'h008
`define OFS_RVTH        12'h00c
`define OFS_OXTH        12'h010
`define OFS_DIOTH       12'h014
`define OFS_LOSDLY      12'h018
`define OFS_MEAS_V      12'h01c
`define OFS_MEAS_I      12'h020
`define OFS_STATUS      12'h024
`define OFS_CLEAR       12'h028

// Control field positions
`define CTL_OV_EN       0
`define CTL_OV_SHUT     1
`define CTL_UV_EN       2
`define CTL_UV_SHUT     3
`define CTL_RV_EN       4
`define CTL_RV_SHUT     5
`define CTL_OX_EN       6
`define CTL_OX_SHUT     7
`define CTL_OX_INV      8
`define CTL_DIO_EN      9
`define CTL_DIO_SHUT    10
`define CTL_LOS_EN      11
`define CTL_LOS_SHUT    12
`define CTL_FR_EN       13
`define CTL_FR_SHUT     14
`define CTL_THREE_PH    15
`define CTL_OVERRIDE    16
`define CTRL_RESET      32'h0000_0000

// Setting ranges (percent, tenths of s, tenths of A)
`define OV_PCT_MIN      8'd105
`define OV_PCT_MAX      8'd135
`define UV_PCT_MIN      8'd60
`define UV_PCT_MAX      8'd95
`define RV_PCT_MIN      8'd10
`define RV_PCT_MAX      8'd100
`define OV_DLY_MIN      12'd20
`define OV_DLY_MAX      12'd300
`define UV_DLY_MIN      12'd100
`define UV_DLY_MAX      12'd1200
`define RV_DLY_MIN      12'd1
`define RV_DLY_MAX      12'd99
`define OX_DLY_MIN      12'd10
`define OX_DLY_MAX      12'd100
`define OX_I_MAX        12'd120
`define DIO_I_MIN       12'd10
`define DIO_I_MAX       12'd100
`define LOS_DLY_MAX     12'd250
`define DIO_DLY         12'd50
`define FR_DLY          12'd100
`define FOC_LIMIT       12'd280
`define LOS_1PH_PCT     8'd50
`define LOS_3PH_PCT     8'd20

`endif

// ### rtl/prot_pkg.sv
/*
 Types for the generator protection supervisor. Assumes prot_cfg.svh.
*/
package prot_pkg;
   // One protection's programmed settings
   typedef struct packed {
      logic [7:0]  level;   // Trip level
      logic [11:0] delay;   // Delay in tenths of s
   } trip_set_t;

   // Fault outcome of one protection
   typedef struct packed {
      logic alarm;          // Tripped as alarm
      logic shut;           // Tripped as shutdown
   } verdict_t;

   // Protection indices
   typedef enum logic [2:0] {
      P_OV, P_UV, P_RV, P_OX, P_DIO, P_LOS, P_FR
   } prot_id_t;
endpackage : prot_pkg

// ### verif/gen_protect_monitor.sv
/*
 Port checker for gen_protect, bound below the module.
 Assumes APB writes to offset 0 load the control word.
*/
`timescale 1ns/100ps
module gen_protect_monitor (
   input wire logic        pclk,       // Clock
   input wire logic        presetn,    // Reset, active low
   input wire logic        psel,       // APB select
   input wire logic        penable,    // APB enable
   input wire logic        pwrite,     // APB direction
   input wire logic [11:0] paddr,      // APB address
   input wire logic [31:0] pwdata,     // APB write data
   input wire logic        pready,     // APB ready
   input wire logic        pslverr,    // APB error
   input wire logic [11:0] field_i,    // Field current
   input wire logic        alarm_drv,  // Alarm driver
   input wire logic        shut_drv,   // Shutdown driver
   input wire logic        fault_led,  // Fault lamp
   input wire logic        can_alarm,  // CAN alarm pulse
   input wire logic        can_shut,   // CAN shutdown pulse
   input wire logic        excite_off, // Excitation cut
   input wire logic        field_oc    // Field overcurrent
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [16:0] ctrl_q;  // Shadow of the control word
   // Track control writes so enables and override are known here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_q <= 17'h00000;
      else if (psel && penable && pwrite && pready && paddr == 12'h000)
         ctrl_q <= pwdata[16:0];
   end
   sequence s_access;
      psel && penable;
   endsequence
   // Four cycles lets a disable flush latched trips first
   sequence s_all_off;
      (ctrl_q == 17'h00000)[*4];
   endsequence
   a_ready_always: assert property (s_access |-> pready)
      else $error("APB access without ready");
   a_unmapped_err: assert property (s_access |-> pslverr == !(paddr inside {12'h000, 12'h004,
      12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h024, 12'h028}))
      else $error("APB error flag wrong");
   a_reset_quiet: assert property ($rose(presetn) |-> !(alarm_drv || excite_off))
      else $error("Outputs active after reset");
   a_all_off: assert property (s_all_off |-> !alarm_drv && !shut_drv)
      else $error("Driver active with all protections off");
   a_alarm_msg: assert property (can_alarm |-> ##[0:2] alarm_drv)
      else $error("Alarm message without alarm driver");
   a_alarm_lamp: assert property ((alarm_drv && !shut_drv)[*3] |-> fault_led)
      else $error("Lamp not steady on alarm");
   a_shut_msg: assert property (can_shut |-> ##[0:2] shut_drv)
      else $error("Shutdown message without driver");
   a_override_hold: assert property ((ctrl_q[16] && !field_oc)[*3] |-> !excite_off)
      else $error("Excitation cut under override");
   a_quiet_cut: assert property
      ((!(ctrl_q[6] || ctrl_q[9] || ctrl_q[11]) && !field_oc)[*3] |-> !excite_off)
      else $error("Excitation cut by non cutting protection");
   a_foc_cut: assert property (field_i >= 12'd280 |-> ##[1:3] (excite_off && field_oc))
      else $error("No instant cut at field overcurrent");
endmodule : gen_protect_monitor

bind gen_protect gen_protect_monitor u_mon (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
   .field_i, .alarm_drv, .shut_drv, .fault_led, .can_alarm, .can_shut,
   .excite_off, .field_oc
);

// ### verif/can_node.sv
/*
 Behavioural CAN J1939 node: counts alarm and shutdown messages.
 Assumes one-cycle request pulses on pclk.
*/
`timescale 1ns/100ps
module can_node (
   input  wire logic pclk,      // Clock
   input  wire logic presetn,   // Reset, active low
   input  wire logic can_alarm, // Alarm message request
   input  wire logic can_shut,  // Shutdown message request
   output int        n_alarm,   // Alarm messages seen
   output int        n_shut     // Shutdown messages seen
);
   // A held request would count as repeats, exposing a stuck pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         n_alarm <= 0;
      else if (can_alarm)
         n_alarm <= n_alarm + 1;
   end
   // Shutdown messages counted apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         n_shut <= 0;
      else if (can_shut)
         n_shut <= n_shut + 1;
   end
endmodule : can_node

// ### verif/tb_top.sv
/*
 Testbench for gen_protect: APB master, field stimulus, CAN node.
 Assumes TICK_CYCLES of 10, so 0.1 s is 10 clocks.
*/
`timescale 1ns/100ps
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr, field_i, ripple_i;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  volt_pct, rvar_pct, sense_pct, imbal_pct;
   logic        phase_lost, fault_reset_n, alarm_drv, shut_drv, fault_led;
   logic        can_alarm, can_shut, excite_off, field_oc;
   int          n_mismatch, total_checks, n_alarm, n_shut, k, h, seed;
   logic [11:0] a;
   logic [31:0] d;
   gen_protect #(.TICK_CYCLES(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .volt_pct, .rvar_pct, .field_i,
      .ripple_i, .sense_pct, .imbal_pct, .phase_lost, .fault_reset_n, .alarm_drv,
      .shut_drv, .fault_led, .can_alarm, .can_shut, .excite_off, .field_oc);
   can_node u_can (.pclk, .presetn, .can_alarm, .can_shut, .n_alarm, .n_shut);
   // 25 MHz clock
   initial pclk = 1'b0;
   always #20 pclk = ~pclk;
   task chk(input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; holds the request until pready is sampled
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      logic rdy;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Answer taken while settled, as it stands at the sampling edge
      do begin
         @(negedge pclk);
         rdy = pready;
         rd = prdata;
         er = pslverr;
         @(posedge pclk);
      end while (rdy !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   // Expected readback of a level/delay register after range clamping
   function automatic logic [31:0] clamp(input logic [11:0] ad, input logic [31:0] wd);
      logic [7:0]  l, lo, hi;
      logic [11:0] t, tl, th;
      case (ad)
         12'h004: begin lo = 8'd105; hi = 8'd135; tl = 12'd20; th = 12'd300; end
         12'h008: begin lo = 8'd60; hi = 8'd95; tl = 12'd100; th = 12'd1200; end
         default: begin lo = 8'd10; hi = 8'd100; tl = 12'd1; th = 12'd99; end
      endcase
      l = wd[7:0] < lo ? lo : (wd[7:0] > hi ? hi : wd[7:0]);
      t = wd[27:16] < tl ? tl : (wd[27:16] > th ? th : wd[27:16]);
      return {4'h0, t, 8'h00, l};
   endfunction : clamp
   task end_sim;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // Watchdog, well past the expected run of about 4000 cycles
   initial begin
      #400000;
      n_mismatch++;
      end_sim();
   end
   initial begin
      seed = 32'hde04359c;
      {psel, penable, pwrite, phase_lost} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {volt_pct, rvar_pct, imbal_pct} = 24'h640000;
      sense_pct = 8'd100;
      {field_i, ripple_i} = 24'h0;
      fault_reset_n = 1'b1;
      presetn = 1'b0;
      tick(12);
      presetn <= 1'b1;
      apb(0, 12'h000, 0);
      chk(rd, 0);
      apb(0, 12'h100, 0);
      chk({er, rd}, 33'h100000000);
      // Corner and random level/delay writes
      for (h = 0; h < 18; h++) begin
         a = 12'h004 + 12'(4 * (h % 3));
         d = h < 3 ? 32'h0 : (h < 6 ? 32'h0fff00ff : $random(seed));
         apb(1, a, d);
         apb(0, a, 0);
         chk(rd, clamp(a, d));
      end
      // Shutdown types selected but every protection disabled
      apb(1, 12'h004, 32'h0014006e);
      apb(1, 12'h000, 32'h000054aa);
      volt_pct <= 8'd136 + 8'($random(seed) & 32'h3f);
      {rvar_pct, field_i, ripple_i, fault_reset_n} <= {8'd120, 12'd200, 12'd200, 1'b0};
      tick(400);
      apb(0, 12'h024, 0);
      chk({rd, alarm_drv, shut_drv, excite_off}, 0);
      {volt_pct, rvar_pct, field_i, ripple_i, fault_reset_n} <= {8'd100, 8'd0, 24'h0, 1'b1};
      // Over voltage alarm, interrupted once to restart the timer
      apb(1, 12'h000, 32'h1);
      volt_pct <= 8'd120;
      tick(150);
      volt_pct <= 8'd100;
      tick(5);
      volt_pct <= 8'd120;
      for (k = 0; k < 300 && alarm_drv !== 1'b1; k++) @(posedge pclk);
      chk(k >= 190 && k <= 215, 1);
      h = 0;
      repeat (60) @(posedge pclk) h += fault_led;
      chk({n_alarm, h, excite_off}, {32'd1, 32'd60, 1'b0});
      volt_pct <= 8'd100;
      apb(1, 12'h028, 32'hff);
      // Fault reset held too long, shutdown type
      apb(1, 12'h000, 32'h6000);
      fault_reset_n <= 1'b0;
      tick(950);
      chk(shut_drv, 0);
      for (k = 0; k < 150 && shut_drv !== 1'b1; k++) @(posedge pclk);
      h = 0;
      repeat (120) @(posedge pclk) h += fault_led;
      chk({shut_drv, n_shut, h > 0 && h < 120, excite_off}, {1'b1, 32'd1, 2'b10});
      fault_reset_n <= 1'b1;
      tick(4);
      apb(1, 12'h028, 32'hff);
      // Over excitation under override, then override lifted
      apb(1, 12'h010, 32'h000a0032);
      apb(1, 12'h000, 32'h10040);
      field_i <= 12'd100;
      for (k = 0; k < 200 && alarm_drv !== 1'b1; k++) @(posedge pclk);
      // CAN node counts the pulse one edge after the driver rises
      tick(2);
      chk({alarm_drv, n_alarm, excite_off}, {1'b1, 32'd2, 1'b0});
      apb(1, 12'h000, 32'h40);
      tick(3);
      chk(excite_off, 1);
      // Inverse time: 1.0 s dial, 5.0 A base, 10.0 A field gives 0.5 s
      field_i <= 12'd0;
      apb(1, 12'h000, 32'h140);
      apb(1, 12'h028, 32'hff);
      tick(2);
      field_i <= 12'd100;
      for (k = 0; k < 200 && excite_off !== 1'b1; k++) @(posedge pclk);
      chk(k >= 44 && k <= 60, 1);
      field_i <= 12'd0;
      apb(1, 12'h000, 32'h200);
      apb(1, 12'h028, 32'hff);
      // Field overcurrent hides the diode alarm
      {field_i, ripple_i} <= {12'd280, 12'd200};
      tick(3);
      chk(field_oc, 1);
      tick(560);
      apb(0, 12'h024, 0);
      chk({rd[9:8], rd[4], alarm_drv}, 4'b1100);
      {field_i, ripple_i} <= 24'h0;
      tick(4);
      apb(1, 12'h028, 32'hff);
      tick(5);
      ripple_i <= 12'd101;
      for (k = 0; k < 600 && excite_off !== 1'b1; k++) @(posedge pclk);
      chk(k >= 490 && k <= 520, 1);
      ripple_i <= 12'd0;
      // Three phase sensing loss by imbalance, 0.5 s delay
      apb(1, 12'h018, 32'h5);
      apb(1, 12'h000, 32'h8800);
      tick(4);
      apb(1, 12'h028, 32'hff);
      imbal_pct <= 8'd19;
      tick(100);
      chk(excite_off, 0);
      imbal_pct <= 8'd20;
      for (k = 0; k < 100 && excite_off !== 1'b1; k++) @(posedge pclk);
      chk(k >= 44 && k <= 70, 1);
      imbal_pct <= 8'd0;
      // Single phase sensing loss at half of set point
      apb(1, 12'h000, 32'h800);
      apb(1, 12'h028, 32'hff);
      sense_pct <= 8'd51;
      tick(100);
      chk(excite_off, 0);
      sense_pct <= 8'd50;
      for (k = 0; k < 100 && excite_off !== 1'b1; k++) @(posedge pclk);
      chk(k >= 44 && k <= 70, 1);
      sense_pct <= 8'd100;
      // Override must not survive a reset in mid-run
      apb(1, 12'h000, 32'h10000);
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      apb(0, 12'h000, 0);
      chk(rd, 0);
      end_sim();
   end
endmodule : tb_top
